//--- src/microcore_flow_control.sv
// Program-flow control of one microcode sequencer core.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "microcore_flow_control_map.svh"

// Behaviour
// RL1 - Three interrupt levels: diagnosis, driver, software.
// RL2 - Diagnosis and driver-fault registers raise interrupts.
// RL3 - Software interrupt instruction requests lowest level.
// RL4 - Taking interrupt saves program counter.
// RL5 - One level active; others queued unless cleared.
// RL6 - Return reloads saved address or entry point.
// RL7 - Resumed wait or jump sees saved feedback.
// RL8 - Return takes one cycle.
// RL9 - Conditional relative jump, 6-bit offset, else next.
// RL10 - Taken relative jump loads offset target.
// RL11 - Far jumps use unchanged 10-bit jump register.
// RL12 - Conditional far jump one cycle, loads register.
// RL13 - Unconditional relative jump in one cycle.
// RL14 - Unconditional far jump in one cycle.
// RL15 - Five wait entries: enable, condition, destination.
// RL16 - Wait destinations are physical addresses.
// RL17 - Entries written singly and persist after wait.
// RL18 - Wait holds counter until enabled condition met.
// RL19 - Table inactive after wait resolves.
// RL20 - Load, store and copy any register.
// RL21 - Two count-load instructions; one updates commands.
// RL22 - Jump-register loads; load group one cycle.
// RL23 - Call saves counter in auxiliary register.
// RL24 - Subroutine return restores auxiliary address.
// RL25 - Lowest satisfied wait entry wins.
// RL26 - Higher queued level dispatched first.
module microcore_flow_control
  import microcore_flow_control_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Instruction issue
  input wire logic op_valid_i,
  input wire op_type op_code_i,
  input wire logic [15:0] op_arg_i,
  input wire logic [63:0] cond_vec_i,
  input wire logic [15:0] ld_data_i,
  // Interrupt sources
  input wire logic [15:0] diag_set_i,
  input wire logic [15:0] fault_pin_i,
  // Register port
  input wire logic [9:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Flow and data outputs
  output logic [9:0] pc_o,
  output logic irq_active_o,
  output logic [9:0] dm_addr_o,
  output logic [15:0] dm_wdata_o,
  output logic dm_we_o,
  output logic [4:0] pdrv_cmd_o
);

  // ****************************************
  // Declarations.
  // ****************************************
  state_type state_r;
  logic [9:0] pc_r, iret_pc_r, entry_r, rel_tgt, far_tgt, pc_inc;
  logic [15:0] regs_r [0:31];
  logic [15:0] diag_r, fault_s1_r, fault_s2_r;
  logic diag_any_q, drv_any_q, in_irq_r, sv_wait_r, restore_r, take, exec;
  logic cnd, hit;
  logic [2:0] pend_r, req, hit_idx;
  logic [63:0] fbk_save_r, cond_now;
  // RL15 five table entries
  logic wt_en_r [0:`WAIT_ENTRIES-1];
  logic [5:0] wt_code_r [0:`WAIT_ENTRIES-1];
  logic [9:0] wt_dest_r [0:`WAIT_ENTRIES-1];
  logic [9:0] vec;

  function automatic logic [9:0] rel_target(input logic [9:0] pc,
                                            input logic [5:0] ofs);
    rel_target = pc + {{4{ofs[5]}}, ofs};
  endfunction

  // ****************************************
  // Decode.
  // ****************************************
  // RL7 feedback restored
  assign cond_now = restore_r ? fbk_save_r : cond_vec_i;
  assign cnd = cond_now[op_arg_i[`F_COND_HI:`F_COND_LO]];
  assign pc_inc = pc_r + 10'h001;
  assign rel_tgt = rel_target(pc_r, op_arg_i[`F_REL_HI:0]);
  // RL11 register selected
  assign far_tgt = op_arg_i[0] ? regs_r[`REG_FAR_B][9:0]
                               : regs_r[`REG_FAR_A][9:0];
  // RL5 one level only
  assign take = !in_irq_r && (pend_r != 3'b000);
  assign exec = op_valid_i && !take && (state_r == ST_RUN);
  // RL26 priority dispatch
  assign vec = pend_r[0] ? `VEC_DIAG : (pend_r[1] ? `VEC_DRV : `VEC_SW);

  // RL25 lowest entry wins
  always_comb begin
    hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = `WAIT_ENTRIES - 1; i >= 0; i--) begin
      if (wt_en_r[i] && cond_now[wt_code_r[i]]) begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // ****************************************
  // Interrupt sources.
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_s1_r <= `RST_WORD;
      fault_s2_r <= `RST_WORD;
    end else begin
      fault_s1_r <= fault_pin_i;
      fault_s2_r <= fault_s1_r;
    end
  end

  // RL2 diagnosis register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      diag_r <= `RST_WORD;
    end else if (reg_wr_i && reg_addr_i == `OFS_DIAG_ERROR) begin
      diag_r <= reg_wdata_i | diag_set_i;
    end else begin
      diag_r <= diag_r | diag_set_i;
    end
  end

  // RL1 RL3 three request levels
  // RL2 rising request edges
  assign req = {exec && op_code_i == OP_REQI,
                (|fault_s2_r) && !drv_any_q,
                (|diag_r) && !diag_any_q};

  // RL5 queued requests
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      diag_any_q <= 1'b0;
      drv_any_q <= 1'b0;
      pend_r <= 3'b000;
    end else begin
      diag_any_q <= |diag_r;
      drv_any_q <= |fault_s2_r;
      if (exec && op_code_i == OP_IRET && op_arg_i[`F_IRET_CLR]) begin
        pend_r <= req;
      end else if (take) begin
        pend_r <= (pend_r & ~(pend_r & ~(pend_r - 3'b001))) | req;
      end else begin
        pend_r <= pend_r | req;
      end
    end
  end

  // ****************************************
  // Program counter and sequencing.
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_r <= `RST_PC;
      state_r <= ST_RUN;
      in_irq_r <= 1'b0;
      iret_pc_r <= `RST_PC;
      sv_wait_r <= 1'b0;
      restore_r <= 1'b0;
      fbk_save_r <= 64'h0;
    end else begin
      restore_r <= 1'b0;
      if (take) begin
        // RL4 save counter
        in_irq_r <= 1'b1;
        iret_pc_r <= pc_r;
        sv_wait_r <= (state_r == ST_WAIT);
        fbk_save_r <= cond_vec_i;
        pc_r <= vec;
        state_r <= ST_RUN;
      end else if (state_r == ST_WAIT) begin
        // RL18 hold then jump
        if (hit) begin
          pc_r <= wt_dest_r[hit_idx];
          state_r <= ST_RUN;
        end
      end else if (exec) begin
        case (op_code_i)
          // RL10 relative taken
          OP_JCR, OP_CALLR: pc_r <= cnd ? rel_tgt : pc_inc;
          // RL12 far conditional
          OP_JCF, OP_CALLF: pc_r <= cnd ? far_tgt : pc_inc;
          // RL13 unconditional relative
          OP_JMPR: pc_r <= rel_tgt;
          // RL14 unconditional far
          OP_JMPF: pc_r <= far_tgt;
          OP_WAIT: state_r <= ST_WAIT;
          // RL6 RL8 one-cycle return
          OP_IRET: begin
            in_irq_r <= 1'b0;
            pc_r <= op_arg_i[`F_IRET_ENTRY] ? entry_r : iret_pc_r;
            state_r <= sv_wait_r ? ST_WAIT : ST_RUN;
            restore_r <= 1'b1;
          end
          // RL24 subroutine return
          OP_RFS: pc_r <= regs_r[`REG_AUX][9:0];
          default: pc_r <= pc_inc;
        endcase
      end
    end
  end

  // ****************************************
  // Wait table.
  // ****************************************
  // RL17 entries written singly
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < `WAIT_ENTRIES; i++) begin
        wt_en_r[i] <= 1'b0;
        wt_code_r[i] <= 6'h00;
        wt_dest_r[i] <= `RST_PC;
      end
    end else if (exec && (op_code_i == OP_CWEF || op_code_i == OP_CWER)
                 && op_arg_i[15:`F_IDX_LO] < 3'(`WAIT_ENTRIES)) begin
      wt_en_r[op_arg_i[15:`F_IDX_LO]] <= op_arg_i[`F_EN];
      wt_code_r[op_arg_i[15:`F_IDX_LO]] <=
        op_arg_i[`F_COND_HI:`F_COND_LO];
      // RL16 physical destination
      wt_dest_r[op_arg_i[15:`F_IDX_LO]] <=
        (op_code_i == OP_CWEF) ? far_tgt : rel_tgt;
    end
  end

  // ****************************************
  // Register file and load group.
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= `RST_WORD;
      end
    end else if (exec) begin
      case (op_code_i)
        // RL20 load and copy
        OP_LOAD: regs_r[op_arg_i[4:0]] <= ld_data_i;
        OP_COPY: regs_r[op_arg_i[4:0]] <= regs_r[op_arg_i[9:5]];
        // RL21 count registers
        OP_LDCA, OP_LDCD:
          regs_r[`REG_EOC_BASE + {3'h0, op_arg_i[1:0]}] <=
            regs_r[op_arg_i[6:2]];
        // RL22 jump registers
        OP_LDJRA: regs_r[`REG_FAR_A] <= {6'h00, op_arg_i[9:0]};
        OP_LDJRB: regs_r[`REG_FAR_B] <= {6'h00, op_arg_i[9:0]};
        // RL23 save return
        OP_CALLR, OP_CALLF: begin
          if (cnd) begin
            regs_r[`REG_AUX] <= {6'h00, pc_inc};
          end
        end
        default: ;
      endcase
    end
  end

  // RL20 store and commands
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dm_addr_o <= 10'h000;
      dm_wdata_o <= `RST_WORD;
      dm_we_o <= 1'b0;
      pdrv_cmd_o <= 5'h00;
    end else begin
      dm_we_o <= exec && op_code_i == OP_STORE;
      if (exec && op_code_i == OP_STORE) begin
        dm_addr_o <= op_arg_i[15:6];
        dm_wdata_o <= regs_r[op_arg_i[4:0]];
      end
      // RL21 command update
      if (exec && op_code_i == OP_LDCA) begin
        pdrv_cmd_o <= op_arg_i[11:7];
      end
    end
  end

  // ****************************************
  // Register port.
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      entry_r <= `RST_ENTRY_POINT;
      reg_rdata_o <= `RST_WORD;
    end else begin
      if (reg_wr_i && reg_addr_i == `OFS_ENTRY_POINT) begin
        entry_r <= reg_wdata_i[9:0];
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `OFS_DIAG_ERROR: reg_rdata_o <= diag_r;
          `OFS_FAULT_STATE: reg_rdata_o <= fault_s2_r;
          `OFS_ENTRY_POINT: reg_rdata_o <= {6'h00, entry_r};
          `OFS_FLOW_STATUS:
            reg_rdata_o <= {10'h000, pend_r, sv_wait_r,
                            state_r == ST_WAIT, in_irq_r};
          default: reg_rdata_o <= `RST_WORD;
        endcase
      end
    end
  end

  assign pc_o = pc_r;
  assign irq_active_o = in_irq_r;

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_save_pc;
    take |=> iret_pc_r == $past(pc_r) && pc_r == $past(vec);
  endproperty
  a_save_pc: assert property (p_save_pc) else $error("pc not saved"); // RL4

  property p_diag_first;
    take && pend_r[0] |=> pc_r == `VEC_DIAG;
  endproperty
  a_diag_first: assert property (p_diag_first) // RL26
    else $error("wrong level taken");

  property p_one_level;
    in_irq_r && !(exec && op_code_i == OP_IRET) |=> in_irq_r && !take;
  endproperty
  a_one_level: assert property (p_one_level) // RL5
    else $error("second level entered");

  property p_iret;
    exec && op_code_i == OP_IRET |=> !in_irq_r
      && pc_r == ($past(op_arg_i[1]) ? $past(entry_r) : $past(iret_pc_r));
  endproperty
  a_iret: assert property (p_iret) else $error("bad return"); // RL6

  property p_jmpr;
    exec && op_code_i == OP_JMPR |=> pc_r == $past(rel_tgt);
  endproperty
  a_jmpr: assert property (p_jmpr) else $error("bad relative jump"); // RL13

  property p_jcr_not;
    exec && op_code_i == OP_JCR && !cnd |=> pc_r == $past(pc_r) + 10'h001;
  endproperty
  a_jcr_not: assert property (p_jcr_not) // RL9
    else $error("untaken jump moved");

  property p_jmpf;
    exec && op_code_i == OP_JMPF |=> pc_r == $past(far_tgt)
      && regs_r[`REG_FAR_A] == $past(regs_r[`REG_FAR_A]);
  endproperty
  a_jmpf: assert property (p_jmpf) else $error("bad far jump"); // RL14

  property p_wait_hold;
    state_r == ST_WAIT && !hit && !take |=> pc_r == $past(pc_r);
  endproperty
  a_wait_hold: assert property (p_wait_hold) // RL18
    else $error("pc moved in wait");

  property p_wait_done;
    state_r == ST_WAIT && hit && !take |=> state_r == ST_RUN;
  endproperty
  a_wait_done: assert property (p_wait_done) // RL19
    else $error("wait not left");

  property p_sw_req;
    exec && op_code_i == OP_REQI |=> pend_r[2];
  endproperty
  a_sw_req: assert property (p_sw_req) else $error("sw request lost"); // RL3

  c_take: cover property (take ##1 in_irq_r);
  c_wait: cover property (state_r == ST_WAIT && hit);
  c_iret: cover property (exec && op_code_i == OP_IRET && sv_wait_r);

endmodule
`default_nettype wire

//--- include/microcore_flow_control_map.svh
// Constants for the microcore program-flow block.
`ifndef MICROCORE_FLOW_CONTROL_MAP_SVH
`define MICROCORE_FLOW_CONTROL_MAP_SVH

// ****************************************
// Register offsets.
// ****************************************
`define OFS_DIAG_ERROR 10'h162
`define OFS_FAULT_STATE 10'h1d2
`define OFS_ENTRY_POINT 10'h300
`define OFS_FLOW_STATUS 10'h301

// ****************************************
// Reset values.
// ****************************************
`define RST_PC 10'h000
`define RST_ENTRY_POINT 10'h000
`define RST_WORD 16'h0000

// ****************************************
// Handler start addresses by level.
// ****************************************
`define VEC_DIAG 10'h3f0
`define VEC_DRV 10'h3f4
`define VEC_SW 10'h3f8

// ****************************************
// Register file slots and table size.
// ****************************************
`define REG_AUX 5'h09
`define REG_FAR_A 5'h0a
`define REG_FAR_B 5'h0b
`define REG_EOC_BASE 5'h10
`define WAIT_ENTRIES 5

// ****************************************
// Operand field positions.
// ****************************************
`define F_REL_HI 5
`define F_COND_LO 6
`define F_COND_HI 11
`define F_EN 12
`define F_IDX_LO 13
`define F_IRET_CLR 0
`define F_IRET_ENTRY 1

`endif

//--- include/microcore_flow_control_pkg.sv
// Types for the microcore program-flow block.
package microcore_flow_control_pkg;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_JCR = 5'h01, OP_JCF = 5'h02, OP_JMPR = 5'h03,
    OP_JMPF = 5'h04, OP_CWEF = 5'h05, OP_CWER = 5'h06, OP_WAIT = 5'h07,
    OP_REQI = 5'h08, OP_IRET = 5'h09, OP_CALLR = 5'h0a, OP_CALLF = 5'h0b,
    OP_RFS = 5'h0c, OP_LOAD = 5'h0d, OP_STORE = 5'h0e, OP_COPY = 5'h0f,
    OP_LDCA = 5'h10, OP_LDCD = 5'h11, OP_LDJRA = 5'h12, OP_LDJRB = 5'h13
  } op_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_WAIT = 2'b10
  } state_type;

endpackage

//--- verif/tb_microcore_flow_control.sv
// Self-checking testbench for the microcore program-flow block.
`timescale 1ns/1ps
`default_nettype none
`include "microcore_flow_control_map.svh"

module tb_microcore_flow_control
  import microcore_flow_control_pkg::*;
;
  logic clk_sys_i;
  logic rst_i;
  logic op_valid_i;
  op_type op_code_i;
  logic [15:0] op_arg_i;
  logic [63:0] cond_vec_i;
  logic [15:0] ld_data_i;
  logic [15:0] diag_set_i;
  logic [15:0] fault_pin_i;
  logic [9:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic [9:0] pc_o;
  logic irq_active_o;
  logic [9:0] dm_addr_o;
  logic [15:0] dm_wdata_o;
  logic dm_we_o;
  logic [4:0] pdrv_cmd_o;
  int n_fail;
  int checked;
  int cyc;
  logic [9:0] pc;
  logic [9:0] v;
  logic [9:0] w;
  logic [9:0] sv;
  logic [5:0] o;
  logic [5:0] c;
  logic [5:0] d;
  logic [15:0] x;
  logic t;

  microcore_flow_control dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_arg_i(op_arg_i), .cond_vec_i(cond_vec_i),
    .ld_data_i(ld_data_i), .diag_set_i(diag_set_i),
    .fault_pin_i(fault_pin_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pc_o(pc_o), .irq_active_o(irq_active_o),
    .dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o), .dm_we_o(dm_we_o),
    .pdrv_cmd_o(pdrv_cmd_o)
  );

  // ****************************************
  // Clock, timeout and helpers.
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  function automatic logic [9:0] rel(input logic [9:0] p, input logic [5:0] f);
    return p + {{4{f[5]}}, f};
  endfunction

  task automatic close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic op(input op_type k, input logic [15:0] a);
    @(posedge clk_sys_i);
    op_valid_i <= 1'b1;
    op_code_i <= k;
    op_arg_i <= a;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      op_valid_i <= 1'b0;
    end
    #1;
  endtask

  task automatic run(input op_type k, input logic [15:0] a,
                     input logic [63:0] cv, input logic [9:0] e);
    op(k, a);
    cond_vec_i <= cv;
    idle(1);
    pc = e;
    chk("pc_o", {6'h00, pc_o}, {6'h00, e});
  endtask

  task automatic wait_pc(input logic [9:0] e);
    int i;
    i = 0;
    while (pc_o !== e && i < 16) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    pc = e;
    chk("pc_o", {6'h00, pc_o}, {6'h00, e});
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] dt);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= dt;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e,
                    input string what);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(what, reg_rdata_o, e);
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_code_i = OP_NOP;
    op_arg_i = 16'h0000;
    cond_vec_i = 64'h0;
    ld_data_i = 16'h0000;
    diag_set_i = 16'h0000;
    fault_pin_i = 16'h0000;
    reg_addr_i = 10'h000;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(32'h2c7db8e1));
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    pc = `RST_PC;
    rd(`OFS_ENTRY_POINT, 16'h0000, "entry_point");
    wr(`OFS_FAULT_STATE, 16'hffff);
    rd(`OFS_FAULT_STATE, 16'h0000, "fault_state");
    rd(10'h2aa, 16'h0000, "unmapped");
    wr(`OFS_ENTRY_POINT, 16'h0155);
    rd(`OFS_ENTRY_POINT, 16'h0155, "entry_point");
    for (int i = 0; i < 24; i++) begin
      o = (i == 0) ? 6'h20 : (i == 1) ? 6'h1f : 6'($urandom);
      c = 6'($urandom);
      t = 1'($urandom);
      if (i % 3 == 0) begin
        run(OP_JMPR, {10'h000, o}, 64'h0, rel(pc, o));
      end else begin
        run(OP_JCR, {4'h0, c, o}, t ? (64'h1 << c) : ~(64'h1 << c),
            t ? rel(pc, o) : pc + 10'h001);
      end
    end
    v = 10'($urandom);
    w = 10'($urandom);
    run(OP_LDJRA, {6'h00, v}, 64'h0, pc + 10'h001);
    run(OP_LDJRB, {6'h00, w}, 64'h0, pc + 10'h001);
    run(OP_JMPF, 16'h0000, 64'h0, v);
    c = 6'($urandom);
    run(OP_JCF, {4'h0, c, 6'h01}, ~(64'h1 << c), pc + 10'h001);
    run(OP_JCF, {4'h0, c, 6'h01}, 64'h1 << c, w);
    run(OP_JMPF, 16'h0000, 64'h0, v);
    x = 16'($urandom);
    ld_data_i <= x;
    run(OP_LOAD, {11'h000, `REG_FAR_A}, 64'h0, pc + 10'h001);
    run(OP_COPY, {6'h00, `REG_FAR_A, `REG_FAR_B}, 64'h0,
        pc + 10'h001);
    run(OP_JMPF, 16'h0001, 64'h0, x[9:0]);
    v = 10'($urandom);
    run(OP_STORE, {v, 1'b0, `REG_FAR_B}, 64'h0, pc + 10'h001);
    chk("dm_we_o", {15'h0000, dm_we_o}, 16'h0001);
    chk("dm_addr_o", {6'h00, dm_addr_o}, {6'h00, v});
    chk("dm_wdata_o", dm_wdata_o, x);
    idle(1);
    chk("dm_we_o", {15'h0000, dm_we_o}, 16'h0000);
    x = 16'($urandom);
    run(OP_LDCA, {4'h0, x[4:0], `REG_FAR_A, x[6:5]}, 64'h0,
        pc + 10'h001);
    chk("pdrv_cmd_o", {11'h000, pdrv_cmd_o}, {11'h000, x[4:0]});
    run(OP_LDCD, {4'h0, ~x[4:0], `REG_FAR_A, 2'h1}, 64'h0,
        pc + 10'h001);
    chk("pdrv_cmd_o", {11'h000, pdrv_cmd_o}, {11'h000, x[4:0]});
    c = 6'($urandom);
    o = 6'($urandom);
    sv = pc + 10'h001;
    run(OP_CALLR, {4'h0, c, o}, 64'h1 << c, rel(pc, o));
    run(OP_NOP, 16'h0000, 64'h0, pc + 10'h001);
    run(OP_RFS, 16'h0000, 64'h0, sv);
    d = c ^ 6'h15;
    v = rel(pc, o);
    run(OP_CWER, {3'd0, 1'b1, c, o}, 64'h0, pc + 10'h001);
    w = 10'($urandom);
    run(OP_LDJRB, {6'h00, w}, 64'h0, pc + 10'h001);
    run(OP_CWEF, {3'd1, 1'b1, d, 6'h01}, 64'h0, pc + 10'h001);
    run(OP_WAIT, 16'h0000, 64'h0, pc);
    idle(4);
    chk("pc_o", {6'h00, pc_o}, {6'h00, pc});
    rd(`OFS_FLOW_STATUS, 16'h0002, "flow_status");
    cond_vec_i <= (64'h1 << c) | (64'h1 << d);
    idle(1);
    chk("pc_o", {6'h00, pc_o}, {6'h00, v});
    run(OP_NOP, 16'h0000, (64'h1 << c) | (64'h1 << d), v + 10'h001);
    run(OP_WAIT, 16'h0000, 64'h0, pc);
    cond_vec_i <= 64'h1 << d;
    idle(1);
    chk("pc_o", {6'h00, pc_o}, {6'h00, w});
    pc = w;
    run(OP_REQI, 16'h0000, 64'h0, pc + 10'h001);
    sv = pc;
    idle(1);
    chk("pc_o", {6'h00, pc_o}, {6'h00, `VEC_SW});
    chk("irq_active_o", {15'h0000, irq_active_o}, 16'h0001);
    pc = `VEC_SW;
    run(OP_REQI, 16'h0000, 64'h0, pc + 10'h001);
    diag_set_i <= 16'h0004;
    idle(1);
    diag_set_i <= 16'h0000;
    idle(3);
    chk("pc_o", {6'h00, pc_o}, {6'h00, pc});
    run(OP_IRET, 16'h0000, 64'h0, sv);
    idle(1);
    chk("pc_o", {6'h00, pc_o}, {6'h00, `VEC_DIAG});
    wr(`OFS_DIAG_ERROR, 16'h0000);
    run(OP_IRET, 16'h0001, 64'h0, sv);
    idle(3);
    chk("irq_active_o", {15'h0000, irq_active_o}, 16'h0000);
    chk("pc_o", {6'h00, pc_o}, {6'h00, sv});
    run(OP_REQI, 16'h0000, 64'h0, pc + 10'h001);
    idle(1);
    run(OP_IRET, 16'h0002, 64'h0, 10'h155);
    x = 16'($urandom) | 16'h0001;
    fault_pin_i <= x;
    sv = pc;
    wait_pc(`VEC_DRV);
    rd(`OFS_FAULT_STATE, x, "fault_state");
    fault_pin_i <= 16'h0000;
    run(OP_IRET, 16'h0001, 64'h0, sv);
    run(OP_WAIT, 16'h0000, 64'h0, pc);
    sv = pc;
    diag_set_i <= 16'h0001;
    idle(1);
    diag_set_i <= 16'h0000;
    wait_pc(`VEC_DIAG);
    wr(`OFS_DIAG_ERROR, 16'h0000);
    run(OP_IRET, 16'h0001, 64'h1 << c, sv);
    idle(1);
    chk("pc_o", {6'h00, pc_o}, {6'h00, sv});
    idle(1);
    chk("pc_o", {6'h00, pc_o}, {6'h00, v});
    close_out();
  end

endmodule

`default_nettype wire
